// >>> pkg/tmr16_defines.vh
// constants for the 16-bit timer with low-power oscillator
// assumes an axi4-lite slave with register index = byte address / 4
`ifndef TMR16_DEFINES_VH
`define TMR16_DEFINES_VH

// register indexes (byte address is four times the index)
`define TMR16_IDX_GIC    8'h0b
`define TMR16_IDX_PIF    8'h0c
`define TMR16_IDX_CNTL   8'h0e
`define TMR16_IDX_CNTH   8'h0f
`define TMR16_IDX_TCTL   8'h10
`define TMR16_IDX_PIE    8'h8c
`define TMR16_IDX_PDIR   8'h20
`define TMR16_IDX_PPIN   8'h21
`define TMR16_IDX_IST    8'h22
`define TMR16_IDX_ICLR   8'h23
`define TMR16_IDX_IEN    8'h24

// timer_control fields
`define TMR16_TC_ON      0
`define TMR16_TC_CS      1
`define TMR16_TC_SYNCB   2
`define TMR16_TC_OSCEN   3
`define TMR16_TC_PS_LO   4
`define TMR16_TC_PS_HI   5
`define TMR16_TC_GE      6

// interrupt control / flag / enable fields and port pin bits
`define TMR16_GIC_PERIPHERAL_IRQ_ENABLE   6
`define TMR16_GIC_GIE    7
`define TMR16_PIF_OVF    0
`define TMR16_PIE_OVF    0
`define TMR16_PIN4       4
`define TMR16_PIN5       5
`define TMR16_IST_OVF    0
`define TMR16_IST_WAKE   1

// reset values
`define TMR16_TCTL_RST   7'h00
`define TMR16_GIC_RST    8'h00
`define TMR16_PDIR_RST   2'h3
`define TMR16_CNT_RST    16'h0000

// instruction clock is aclk divided by four
`define TMR16_FOSC_LAST  2'h3

// axi responses
`define TMR16_RESP_OKAY  2'h0
`define TMR16_RESP_ERR   2'h2

`endif

// >>> hw/tmr16_prescale.v
// prescaler of the 16-bit timer: passes 1 of 1, 2, 4 or 8 ticks
// assumes tick_in is a one-cycle enable on aclk
`timescale 1ns/100ps
`default_nettype none
module tmr16_prescale (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       clear,
    input  wire       tick_in,
    input  wire [1:0] sel,
    output wire       tick_out
);

    reg  [2:0] cnt;
    wire [2:0] mask;

    assign mask = (sel == 2'h0) ? 3'h0 :
                  (sel == 2'h1) ? 3'h1 :
                  (sel == 2'h2) ? 3'h3 : 3'h7;
    // tick leaves when the low bits selected by the ratio are all ones
    assign tick_out = tick_in && ((cnt & mask) == mask);

    always @(posedge aclk) begin
        if (!aresetn || clear) begin
            cnt <= 3'h0;
        end else if (tick_in) begin
            cnt <= cnt + 3'h1;
        end
    end

endmodule
`default_nettype wire

// >>> hw/tmr16_top.v
// 16-bit timer/counter with low-power oscillator, axi4-lite registers
// assumes one clock aclk; pins and the oscillator are sampled into it
`timescale 1ns/100ps
`default_nettype none
`include "tmr16_defines.vh"

module tmr16_top (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        other_reset,
    input  wire        sleep_mode,
    input  wire        sys_clk_internal,
    input  wire        osc_input_pin,
    input  wire        gate_pin,
    input  wire        port_pin_4,
    input  wire        port_pin_5,
    output reg         osc_amp_output_pin,
    output reg         osc_running,
    output reg         pin4_direction,
    output reg         pin5_direction,
    output reg         wake_request,
    output reg         isr_vector,
    output reg         irq,
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [31:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);

    // register state
    reg  [6:0]  timer_control;
    reg  [7:0]  global_interrupt_control;
    reg         overflow_flag;
    reg         overflow_irq_enable;
    reg  [15:0] count;
    reg  [1:0]  pin_dir;
    reg  [1:0]  irq_status;
    reg  [1:0]  irq_enable;

    // pin synchronisers: osc, gate, pin4, pin5, sysclk select
    reg  [4:0]  sync_a;
    reg  [4:0]  sync_b;
    reg         osc_prev;
    reg         osc_armed;
    reg         ext_edge_d;
    reg  [1:0]  fosc_cnt;

    // bus state
    reg         aw_held;
    reg  [7:0]  aw_idx;
    reg         w_held;
    reg  [7:0]  w_byte;
    reg         w_lane0;

    wire        osc_s, gate_s, sysint_s, timer_on, ext_src, async_mode;
    wire        osc_en, osc_ok, ext_edge, ext_tick, int_tick, src_tick;
    wire        gate_ok, run_ok, pre_tick, count_inc, ovf, wr_go, wr_ok;
    wire        pre_clear, wake_cond;
    wire [7:0]  wr_idx;

    assign osc_s    = sync_b[0];
    assign gate_s   = sync_b[1];
    assign sysint_s = sync_b[4];

    assign timer_on   = timer_control[`TMR16_TC_ON];
    assign ext_src    = timer_control[`TMR16_TC_CS];
    assign osc_en     = timer_control[`TMR16_TC_OSCEN];
    assign async_mode = ext_src && timer_control[`TMR16_TC_SYNCB];

    // shared circuit: no oscillation unless the core runs off intosc
    assign osc_ok = !osc_en || sysint_s;

    // register index from a byte address
    function [7:0] idx_of;
        input [31:0] addr;
        begin
            idx_of = addr[9:2];
        end
    endfunction

    function mapped;
        input [7:0] idx;
        begin
            mapped = (idx == `TMR16_IDX_GIC)  || (idx == `TMR16_IDX_PIF)  ||
                     (idx == `TMR16_IDX_CNTL) || (idx == `TMR16_IDX_CNTH) ||
                     (idx == `TMR16_IDX_TCTL) || (idx == `TMR16_IDX_PIE)  ||
                     (idx == `TMR16_IDX_PDIR) || (idx == `TMR16_IDX_PPIN) ||
                     (idx == `TMR16_IDX_IST)  || (idx == `TMR16_IDX_ICLR) ||
                     (idx == `TMR16_IDX_IEN);
        end
    endfunction

    always @(posedge aclk) begin
        if (!aresetn) begin
            sync_a <= 5'h00;
            sync_b <= 5'h00;
        end else begin
            sync_a <= {sys_clk_internal, port_pin_5, port_pin_4,
                       gate_pin, osc_input_pin};
            sync_b <= sync_a;
        end
    end

    // a falling edge must be seen before the first counted rising edge
    always @(posedge aclk) begin
        if (!aresetn) begin
            osc_prev   <= 1'b0;
            osc_armed  <= 1'b0;
            ext_edge_d <= 1'b0;
        end else begin
            osc_prev   <= osc_s;
            ext_edge_d <= ext_edge;
            if (!ext_src) begin
                osc_armed <= 1'b0;
            end else if (!osc_s) begin
                osc_armed <= 1'b1;
            end
        end
    end

    // external edges arrive already sampled by aclk, so the wrap seen
    // on the counter is an aclk event before it reaches the flag
    assign ext_edge = osc_ok && osc_armed && osc_s && !osc_prev;
    // synchronised mode takes one more stage of delay
    assign ext_tick = timer_control[`TMR16_TC_SYNCB] ? ext_edge :
                      ext_edge_d;

    always @(posedge aclk) begin
        if (!aresetn) begin
            fosc_cnt <= 2'h0;
        end else begin
            fosc_cnt <= fosc_cnt + 2'h1;
        end
    end

    // instruction clock stops in sleep
    assign int_tick = (fosc_cnt == `TMR16_FOSC_LAST) && !sleep_mode;
    assign src_tick = ext_src ? ext_tick : int_tick;

    assign gate_ok = !timer_control[`TMR16_TC_GE] || !gate_s;
    // only the asynchronous counter keeps counting in sleep
    assign run_ok = timer_on && gate_ok &&
                    (!sleep_mode || async_mode);

    assign wr_go  = aw_held && w_held && !s_axi_bvalid;
    assign wr_idx = aw_idx;
    assign wr_ok  = wr_go && w_lane0;
    assign pre_clear = wr_ok && ((wr_idx == `TMR16_IDX_CNTL) ||
                                 (wr_idx == `TMR16_IDX_CNTH));

    tmr16_prescale u_prescale (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .clear    (pre_clear),
        .tick_in  (src_tick && run_ok),
        .sel      (timer_control[`TMR16_TC_PS_HI:`TMR16_TC_PS_LO]),
        .tick_out (pre_tick)
    );

    assign count_inc = pre_tick;
    assign ovf = count_inc && (count == 16'hffff);

    // a byte write wins over a concurrent increment
    always @(posedge aclk) begin
        if (!aresetn) begin
            count <= `TMR16_CNT_RST;
        end else if (wr_ok && wr_idx == `TMR16_IDX_CNTL) begin
            count[7:0] <= w_byte;
        end else if (wr_ok && wr_idx == `TMR16_IDX_CNTH) begin
            count[15:8] <= w_byte;
        end else if (count_inc) begin
            count <= count + 16'h0001;
        end
    end

    // control survives other resets; only power-on clears it
    always @(posedge aclk) begin
        if (!aresetn) begin
            timer_control <= `TMR16_TCTL_RST;
            pin_dir       <= `TMR16_PDIR_RST;
        end else if (wr_ok && wr_idx == `TMR16_IDX_TCTL) begin
            timer_control <= w_byte[6:0];
        end else if (wr_ok && wr_idx == `TMR16_IDX_PDIR) begin
            pin_dir <= {w_byte[`TMR16_PIN5], w_byte[`TMR16_PIN4]};
        end
    end

    always @(posedge aclk) begin
        if (!aresetn || other_reset) begin
            global_interrupt_control <= `TMR16_GIC_RST;
            overflow_irq_enable      <= 1'b0;
            irq_enable               <= 2'h0;
        end else if (wr_ok) begin
            if (wr_idx == `TMR16_IDX_GIC) begin
                global_interrupt_control <= w_byte;
            end
            if (wr_idx == `TMR16_IDX_PIE) begin
                overflow_irq_enable <= w_byte[`TMR16_PIE_OVF];
            end
            if (wr_idx == `TMR16_IDX_IEN) begin
                irq_enable <= w_byte[1:0];
            end
        end
    end

    // sticky flags: a new event wins over the software clear
    always @(posedge aclk) begin
        if (!aresetn || other_reset) begin
            overflow_flag <= 1'b0;
            irq_status    <= 2'h0;
        end else begin
            if (wr_ok && wr_idx == `TMR16_IDX_PIF) begin
                overflow_flag <= w_byte[`TMR16_PIF_OVF] | ovf;
            end else begin
                overflow_flag <= overflow_flag | ovf;
            end
            if (wr_ok && wr_idx == `TMR16_IDX_ICLR) begin
                irq_status <= (irq_status & ~w_byte[1:0]) |
                              {wake_cond & ~wake_request, ovf};
            end else begin
                irq_status <= irq_status |
                              {wake_cond & ~wake_request, ovf};
            end
        end
    end

    // wake needs the flag plus both enables; software must also set
    // timer_on for an overflow to raise the flag, or write 1 to PIF
    assign wake_cond = sleep_mode && overflow_flag && overflow_irq_enable &&
                       global_interrupt_control[`TMR16_GIC_PERIPHERAL_IRQ_ENABLE];

    always @(posedge aclk) begin
        if (!aresetn) begin
            wake_request       <= 1'b0;
            isr_vector         <= 1'b0;
            irq                <= 1'b0;
            osc_running        <= 1'b0;
            osc_amp_output_pin <= 1'b0;
            pin4_direction     <= 1'b1;
            pin5_direction     <= 1'b1;
        end else begin
            wake_request <= wake_cond;
            isr_vector   <= overflow_flag && overflow_irq_enable &&
                            global_interrupt_control[`TMR16_GIC_PERIPHERAL_IRQ_ENABLE] &&
                            global_interrupt_control[`TMR16_GIC_GIE];
            irq          <= |(irq_status & irq_enable);
            // sleep does not gate the oscillator
            osc_running  <= osc_en && sysint_s;
            osc_amp_output_pin <= osc_en && sysint_s && !osc_s;
            pin4_direction <= osc_en | pin_dir[0];
            pin5_direction <= osc_en | pin_dir[1];
        end
    end

    // write channel: address and data taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            aw_idx        <= 8'h00;
            w_held        <= 1'b0;
            w_byte        <= 8'h00;
            w_lane0       <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `TMR16_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held       <= 1'b1;
                aw_idx        <= idx_of(s_axi_awaddr);
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held       <= 1'b1;
                w_byte       <= s_axi_wdata[7:0];
                w_lane0      <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(aw_idx) ? `TMR16_RESP_OKAY :
                                `TMR16_RESP_ERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_held       <= 1'b0;
                w_held        <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // read mux; oscillator-owned pins read as zero
    function [7:0] rd_mux;
        input [7:0] idx;
        begin
            case (idx)
                `TMR16_IDX_GIC:  rd_mux = global_interrupt_control;
                `TMR16_IDX_PIF:  rd_mux = {7'h00, overflow_flag};
                `TMR16_IDX_CNTL: rd_mux = count[7:0];
                `TMR16_IDX_CNTH: rd_mux = count[15:8];
                `TMR16_IDX_TCTL: rd_mux = {1'b0, timer_control};
                `TMR16_IDX_PIE:  rd_mux = {7'h00, overflow_irq_enable};
                `TMR16_IDX_PDIR: rd_mux = {2'h0, pin5_direction,
                                           pin4_direction, 4'h0};
                `TMR16_IDX_PPIN: rd_mux = {2'h0, sync_b[3] & ~osc_en,
                                           sync_b[2] & ~osc_en,
                                           4'h0};
                `TMR16_IDX_IST:  rd_mux = {6'h00, irq_status};
                `TMR16_IDX_IEN:  rd_mux = {6'h00, irq_enable};
                default:         rd_mux = 8'h00;
            endcase
        end
    endfunction

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `TMR16_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h000000, rd_mux(idx_of(s_axi_araddr))};
            s_axi_rresp   <= mapped(idx_of(s_axi_araddr)) &&
                             idx_of(s_axi_araddr) != `TMR16_IDX_ICLR ?
                             `TMR16_RESP_OKAY : `TMR16_RESP_ERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule
`default_nettype wire

// >>> verification/tmr16_props.sv
// checker for the bus handshakes and pin outputs of the timer block
// assumes binding to tmr16_top, everything in the aclk domain
`timescale 1ns/100ps
`default_nettype none
module tmr16_props (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        sleep_mode,
    input wire logic        osc_running,
    input wire logic        pin4_direction,
    input wire logic        pin5_direction,
    input wire logic        wake_request,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    a_wr_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
        else $error("write not answered two cycles after take");
    a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read not answered one cycle after take");
    a_b_holds: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before bready");
    a_r_holds: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before rready");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while answer pending");
    a_aw_refused: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_osc_pins: assert property (osc_running
        |-> pin4_direction && pin5_direction)
        else $error("pins not forced to input with oscillator on");
    a_wake_sleep: assert property (wake_request |-> $past(sleep_mode))
        else $error("wake request outside sleep");
endmodule

bind tmr16_top tmr16_props i_props (
    .aclk, .aresetn, .sleep_mode, .osc_running, .pin4_direction,
    .pin5_direction, .wake_request, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready
);
`default_nettype wire

// >>> verification/tmr16_xtal.sv
// crystal or external clock source on the oscillator input pin
// assumes the bench calls burst for whole clock periods
`timescale 1ns/100ps
`default_nettype none
module tmr16_xtal #(
    parameter realtime PERIOD = 160.0
) (
    output var logic osc_input_pin
);
    // stands low between bursts, so a low precedes every rise
    initial osc_input_pin = 1'b0;
    task automatic burst(input int n);
        #3.3;
        repeat (n) begin
            osc_input_pin = 1'b1;
            #(PERIOD / 2);
            osc_input_pin = 1'b0;
            #(PERIOD / 2);
        end
    endtask
endmodule
`default_nettype wire

// >>> verification/tmr16_top_tb.sv
// self-checking bench of the 16-bit timer block
// assumes aclk at 125 MHz and the crystal model on the oscillator pin
`timescale 1ns/100ps
`default_nettype none
`include "tmr16_defines.vh"
module tmr16_top_tb;
    logic        aclk, aresetn, other_reset, sleep_mode, sys_clk_internal;
    logic        osc_input_pin, gate_pin, port_pin_4, port_pin_5;
    logic        osc_amp_output_pin, osc_running, pin4_direction;
    logic        pin5_direction, wake_request, isr_vector, irq;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    int          errors, n_checks;

    tmr16_top i_dut (
        .aclk, .aresetn, .other_reset, .sleep_mode, .sys_clk_internal,
        .osc_input_pin, .gate_pin, .port_pin_4, .port_pin_5,
        .osc_amp_output_pin, .osc_running, .pin4_direction,
        .pin5_direction, .wake_request, .isr_vector, .irq,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready
    );
    tmr16_xtal i_xtal (.osc_input_pin);

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    task automatic chk(input logic [35:0] got, exp, input string m);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got,
                     exp);
        end
    endtask

    task automatic stop_test;
        $display("errors %0d checks %0d", errors, n_checks);
        if (errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wr(input logic [7:0] idx, d, input logic [1:0] er = 0);
        int t;
        @(posedge aclk);
        s_axi_awaddr <= {22'h0, idx, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        t = 0;
        do begin
            @(posedge aclk);
            t++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && t < 50);
        // late ready lets the response hold checks see a waiting answer
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
        chk({s_axi_bvalid, s_axi_bresp}, {1'b1, er}, "write response");
    endtask

    task automatic rd(input logic [7:0] idx, e, input logic [1:0] er = 0);
        int t;
        @(posedge aclk);
        s_axi_araddr <= {22'h0, idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        t = 0;
        do begin
            @(posedge aclk);
            t++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && t < 50);
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
        chk({s_axi_rvalid, s_axi_rresp, s_axi_rdata}, {1'b1, er, 24'h0, e},
            "read");
    endtask

    task automatic wait_irq(input int lim, output int t);
        t = 0;
        while (irq !== 1'b1 && t < lim) begin
            @(posedge aclk);
            t++;
        end
    endtask

    task automatic setcnt(input logic [15:0] v);
        wr(`TMR16_IDX_CNTH, v[15:8]);
        wr(`TMR16_IDX_CNTL, v[7:0]);
    endtask

    task automatic clr;
        wr(`TMR16_IDX_TCTL, 8'h00);
        wr(`TMR16_IDX_PIF, 8'h00);
        wr(`TMR16_IDX_ICLR, 8'h03);
        repeat (2) @(posedge aclk);
    endtask

    task automatic pulse_other_reset;
        @(posedge aclk);
        other_reset <= 1'b1;
        @(posedge aclk);
        other_reset <= 1'b0;
    endtask

    task automatic t_regs;
        rd(`TMR16_IDX_TCTL, 8'h00);
        rd(`TMR16_IDX_PDIR, 8'h30);
        rd(8'h3f, 8'h00, 2'h2);
        wr(8'h3f, 8'h55, 2'h2);
        rd(`TMR16_IDX_ICLR, 8'h00, 2'h2);
        wr(`TMR16_IDX_TCTL, 8'hf6);
        wr(`TMR16_IDX_GIC, 8'hc0);
        setcnt(16'ha55a);
        pulse_other_reset;
        rd(`TMR16_IDX_TCTL, 8'h76);
        rd(`TMR16_IDX_GIC, 8'h00);
        rd(`TMR16_IDX_CNTL, 8'h5a);
        rd(`TMR16_IDX_CNTH, 8'ha5);
        wr(`TMR16_IDX_TCTL, 8'h00);
    endtask

    task automatic t_osc;
        wr(`TMR16_IDX_PDIR, 8'h00);
        rd(`TMR16_IDX_PPIN, 8'h30);
        wr(`TMR16_IDX_TCTL, 8'h08);
        repeat (8) @(posedge aclk);
        chk(osc_running, 1'b1, "oscillator on");
        chk({pin4_direction, pin5_direction}, 2'b11, "forced");
        rd(`TMR16_IDX_PPIN, 8'h00);
        rd(`TMR16_IDX_PDIR, 8'h30);
        sleep_mode <= 1'b1;
        repeat (8) @(posedge aclk);
        chk(osc_running, 1'b1, "runs in sleep");
        sleep_mode <= 1'b0;
        sys_clk_internal <= 1'b0;
        repeat (8) @(posedge aclk);
        chk(osc_running, 1'b0, "shared oscillator");
        sys_clk_internal <= 1'b1;
        wr(`TMR16_IDX_TCTL, 8'h00);
        repeat (4) @(posedge aclk);
        chk({pin4_direction, pin5_direction}, 2'b00, "released");
    endtask

    task automatic t_ovf;
        int t;
        wr(`TMR16_IDX_IEN, 8'h01);
        for (int ps = 0; ps < 4; ps++) begin
            setcnt(16'hffff);
            wr(`TMR16_IDX_TCTL, {2'h0, ps[1:0], 4'h1});
            wait_irq(99, t);
            chk(t + 4 >= (4 << ps) && t <= (4 << ps) + 6, 1, "ratio");
            wr(`TMR16_IDX_TCTL, 8'h00);
            rd(`TMR16_IDX_PIF, 8'h01);
            rd(`TMR16_IDX_CNTH, 8'h00);
            rd(`TMR16_IDX_IST, 8'h01);
            clr;
            chk(irq, 1'b0, "irq cleared");
        end
    endtask

    task automatic t_hold;
        int t;
        setcnt(16'hffff);
        gate_pin <= 1'b1;
        wr(`TMR16_IDX_TCTL, 8'h41);
        wait_irq(80, t);
        chk(irq, 1'b0, "gate high holds");
        sleep_mode <= 1'b1;
        gate_pin <= 1'b0;
        wait_irq(80, t);
        chk(irq, 1'b0, "sleep holds internal count");
        sleep_mode <= 1'b0;
        wait_irq(20, t);
        chk(irq, 1'b1, "gate low counts");
        clr;
    endtask

    task automatic t_ext;
        wr(`TMR16_IDX_TCTL, 8'h08);
        repeat (50) @(posedge aclk);
        wr(`TMR16_IDX_PIE, 8'h01);
        wr(`TMR16_IDX_GIC, 8'h40);
        setcnt(16'hfffe);
        wr(`TMR16_IDX_TCTL, 8'h0f);
        sleep_mode <= 1'b1;
        i_xtal.burst(1);
        repeat (8) @(posedge aclk);
        chk(irq, 1'b0, "one edge short");
        chk(osc_amp_output_pin, 1'b1, "amplifier out");
        i_xtal.burst(1);
        repeat (8) @(posedge aclk);
        chk({wake_request, isr_vector, irq}, 3'b101, "wake");
        wr(`TMR16_IDX_GIC, 8'hc0);
        repeat (2) @(posedge aclk);
        chk(isr_vector, 1'b1, "vector");
        rd(`TMR16_IDX_IST, 8'h03);
        clr;
        setcnt(16'hfffe);
        wr(`TMR16_IDX_TCTL, 8'h0b);
        i_xtal.burst(3);
        repeat (8) @(posedge aclk);
        chk(irq, 1'b0, "synced holds in sleep");
        sleep_mode <= 1'b0;
        i_xtal.burst(2);
        repeat (8) @(posedge aclk);
        chk(irq, 1'b1, "synced counts");
        clr;
    endtask

    initial begin
        #200us;
        errors++;
        stop_test;
    end

    initial begin
        aresetn = 1'b0;
        other_reset = 1'b0;
        sleep_mode = 1'b0;
        sys_clk_internal = 1'b1;
        gate_pin = 1'b0;
        port_pin_4 = 1'b1;
        port_pin_5 = 1'b1;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        errors = 0;
        n_checks = 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        t_osc;
        t_ovf;
        t_hold;
        t_ext;
        stop_test;
    end
endmodule
`default_nettype wire
